// ---- dv/gpd_pin_model.sv ----
// far-side pins: a pin follows its driver when enabled, else an outside level
// assumes outside levels come from the bench; no pulls, so undriven pins never hold
`timescale 1ns/100ps
module gpd_pin_model (
	input wire logic [7:0] p1_out,
	input wire logic [7:0] p1_oe,
	input wire logic [7:0] p2_out,
	input wire logic [7:0] p2_oe,
	input wire logic [7:0] ext1,
	input wire logic [7:0] ext2,
	output logic [7:0] p1_in,
	output logic [7:0] p2_in
);
	assign p1_in = (p1_oe & p1_out) | (~p1_oe & ext1);
	assign p2_in = (p2_oe & p2_out) | (~p2_oe & ext2);
endmodule : gpd_pin_model

// ---- dv/gpd_port_properties.sv ----
// port-level assertions for the two-port gpio block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/100ps
`include "gpd_defines.svh"
module gpd_port_properties (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] p1_pin_out,
	input wire logic [7:0] p1_pin_oe,
	input wire logic [7:0] p1_alt_oe,
	input wire logic [7:0] p1_pin_func,
	input wire logic [7:0] second_port_pins_in,
	input wire logic [7:0] second_port_pins_oe,
	input wire logic [7:0] tmr_sel,
	input wire logic [7:0] tmr_oe,
	input wire logic [7:0] p2_pin_level
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence rd_at(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence
	// driver is registered, so the timer must stay off for the cycle after the write
	sequence p2_dir_wr;
		reg_wr && reg_addr == `GPD_ADDR_P2_DIR ##1 tmr_sel == 8'h00;
	endsequence

	AST_P1_BIT3_NO_PIN: assert property ((p1_pin_oe[3] | p1_pin_out[3]) == 1'b0)
		else $error("port 1 bit 3 driven");
	AST_RDATA_ONE_CYCLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	AST_P1_DATA_BIT3_ONE: assert property (rd_at(`GPD_ADDR_P1_DATA) |=> reg_rdata[3])
		else $error("port 1 data bit 3 not one");
	AST_DIR_READS_ZERO: assert property (
		rd_at(`GPD_ADDR_P1_DIR) or rd_at(`GPD_ADDR_P2_DIR) |=> reg_rdata == 8'h00)
		else $error("direction read not zero");
	AST_P2_TIMER_WINS: assert property ($past(arst_n) |->
		((second_port_pins_oe ^ $past(tmr_oe)) & $past(tmr_sel)) == 8'h00)
		else $error("timer enable not on port 2");
	AST_P2_DIR_DRIVES: assert property (p2_dir_wr |=> second_port_pins_oe == $past(reg_wdata, 2))
		else $error("port 2 direction not applied");
	AST_P1_SELECTOR_WINS: assert property ($past(arst_n) |->
		((p1_pin_oe ^ $past(p1_alt_oe)) & $past(p1_pin_func) & 8'hf7) == 8'h00)
		else $error("peripheral enable not on port 1");
	AST_P2_LEVEL_TWO_EDGES: assert property ($past(arst_n) && $past(arst_n, 2) |->
		p2_pin_level == $past(second_port_pins_in, 2))
		else $error("port 2 level latency wrong");
endmodule : gpd_port_properties

bind gpd_port_top gpd_port_properties u_props (.ref_clk(ref_clk), .arst_n(arst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .p1_pin_out(p1_pin_out), .p1_pin_oe(p1_pin_oe),
	.p1_alt_oe(p1_alt_oe), .p1_pin_func(p1_pin_func), .second_port_pins_in(second_port_pins_in),
	.second_port_pins_oe(second_port_pins_oe), .tmr_sel(tmr_sel), .tmr_oe(tmr_oe),
	.p2_pin_level(p2_pin_level));

// ---- dv/gpio_port_direction_data_bench.sv ----
// self-checking bench for the two-port gpio block
// assumes the pin model closes the loop from pin drive back to pin level
`timescale 1ns/100ps
`include "gpd_defines.svh"
module gpio_port_direction_data_bench;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, p1_alt_out = 8'h00, p1_alt_oe = 8'h00;
	logic [7:0] tmr_sel = 8'h00, tmr_out = 8'h00, tmr_oe = 8'h00, ext1 = 8'h00, ext2 = 8'h00;
	logic [7:0] reg_rdata, p1_pin_in, p1_pin_out, p1_pin_oe, p1_pin_func, p1_pin_level;
	logic [7:0] p2_in, p2_out, p2_oe, p2_pin_level, w, pin1, pin2, e1oe, e1out, e2oe, e2out;
	// model: p1 dir, p1 data, selector, p2 dir, p2 data
	logic [7:0] m[5];
	logic [7:0] ad[5] = '{`GPD_ADDR_P1_DIR, `GPD_ADDR_P1_DATA, `GPD_ADDR_P1_FUNC,
		`GPD_ADDR_P2_DIR, `GPD_ADDR_P2_DATA};
	int fail_count = 0;
	int cmp_count = 0;

	always #10 ref_clk = ~ref_clk;

	gpd_port_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.p1_pin_in(p1_pin_in), .p1_pin_out(p1_pin_out), .p1_pin_oe(p1_pin_oe),
		.p1_alt_out(p1_alt_out), .p1_alt_oe(p1_alt_oe), .p1_pin_func(p1_pin_func),
		.p1_pin_level(p1_pin_level), .second_port_pins_in(p2_in), .second_port_pins_out(p2_out),
		.second_port_pins_oe(p2_oe), .tmr_sel(tmr_sel), .tmr_out(tmr_out), .tmr_oe(tmr_oe),
		.p2_pin_level(p2_pin_level));
	gpd_pin_model pins (.p1_out(p1_pin_out), .p1_oe(p1_pin_oe), .p2_out(p2_out),
		.p2_oe(p2_oe), .ext1(ext1), .ext2(ext2), .p1_in(p1_pin_in), .p2_in(p2_in));

	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %0t read got %h exp %h", $time, g, e);
		end
	endtask : chk_rd

	task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %0t pin got %h exp %h", $time, g, e);
		end
	endtask : chk_pin

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk_rd(reg_rdata, e);
	endtask : rd

	task automatic predict;
		e1oe = ((m[2] & p1_alt_oe) | (~m[2] & m[0])) & 8'hf7;
		e1out = ((m[2] & p1_alt_out) | (~m[2] & m[1])) & 8'hf7;
		e2oe = (tmr_sel & tmr_oe) | (~tmr_sel & m[3]);
		e2out = (tmr_sel & tmr_out) | (~tmr_sel & m[4]);
		// the level port carries all eight pins; only the register view hides bit 3
		pin1 = (e1oe & e1out) | (~e1oe & ext1);
		pin2 = (e2oe & e2out) | (~e2oe & ext2);
	endtask : predict

	task automatic rst_check;
		arst_n <= 1'b0;
		m = '{default: 8'h00};
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1 predict();
		chk_pin(p1_pin_out, e1out);
		chk_pin(p2_oe, e2oe);
		chk_pin(p1_pin_func, 8'h00);
		rd(`GPD_ADDR_P1_DATA, pin1 | 8'h08);
		rd(`GPD_ADDR_P2_DIR, 8'h00);
		$display("reset test done");
	endtask : rst_check

	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		summarize();
	end

	initial begin
		void'($urandom(25060));
		ext1 <= 8'($urandom);
		ext2 <= 8'($urandom);
		rst_check();
		for (int i = 0; i < 24; i++) begin
			for (int j = 0; j < 5; j++) begin
				w = 8'($urandom);
				m[j] = (j > 2) ? w : (w & 8'hf7);
				wr(ad[j], w);
			end
			@(posedge ref_clk);
			{p1_alt_out, p1_alt_oe, tmr_sel, tmr_out} <= $urandom;
			{tmr_oe, ext1, ext2} <= 24'($urandom);
			repeat (4) @(posedge ref_clk);
			#1 predict();
			chk_pin(p1_pin_oe, e1oe);
			chk_pin(p1_pin_out, e1out);
			chk_pin(p2_oe, e2oe);
			chk_pin(p2_out, e2out);
			chk_pin(p1_pin_level, pin1);
			chk_pin(p2_pin_level, pin2);
			chk_pin(p1_pin_func, m[2]);
			rd(`GPD_ADDR_P1_DATA, (m[0] & m[1]) | (~m[0] & pin1) | 8'h08);
			rd(`GPD_ADDR_P2_DATA, (m[3] & m[4]) | (~m[3] & pin2));
			rd(`GPD_ADDR_P1_FUNC, m[2]);
			rd(`GPD_ADDR_P1_DIR, 8'h00);
			rd(`GPD_ADDR_P1_LEVEL, pin1 & 8'hf7);
			rd(`GPD_ADDR_P2_LEVEL, pin2);
		end
		$display("random test done");
		rd(8'h09, 8'h00);
		rd(`GPD_ADDR_ERR, 8'h02);
		wr(`GPD_ADDR_P1_LEVEL, 8'h5a);
		rd(`GPD_ADDR_ERR, 8'h03);
		wr(`GPD_ADDR_ERR, 8'h03);
		rd(`GPD_ADDR_ERR, 8'h00);
		$display("error flag test done");
		// a second reset in mid-run must clear registers with the timer still active
		rst_check();
		summarize();
	end
endmodule : gpio_port_direction_data_bench

// ---- rtl/gpd_defines.svh ----
// register offsets, field positions, reset values for the two-port gpio block
// assumes byte addresses on an 8-bit register port
`ifndef GPD_DEFINES_SVH
`define GPD_DEFINES_SVH

`define GPD_ADDR_P1_DIR 8'h00
`define GPD_ADDR_P1_DATA 8'h01
`define GPD_ADDR_P2_DIR 8'h02
`define GPD_ADDR_P2_DATA 8'h03
`define GPD_ADDR_P1_FUNC 8'h04
`define GPD_ADDR_P1_LEVEL 8'h05
`define GPD_ADDR_P2_LEVEL 8'h06
`define GPD_ADDR_ERR 8'h07

`define GPD_P1_RSVD_BIT 3
`define GPD_P1_IMPL_MASK 8'hf7
`define GPD_P1_RSVD_MASK 8'h08

`define GPD_DIR_RESET 8'h00
`define GPD_DATA_RESET 8'h00
`define GPD_FUNC_RESET 8'h00
`define GPD_RDATA_RESET 8'h00
`define GPD_UNMAPPED_RDATA 8'h00
`define GPD_DIR_RDATA 8'h00

`define GPD_ERR_WR_BIT 0
`define GPD_ERR_RD_BIT 1
`define GPD_ERR_MASK 8'h03

`endif

// ---- rtl/gpd_pin_drive.sv ----
// per-bit pin driver: alternate function wins, else general i/o direction and data
// assumes alt inputs come from logic on ref_clk; outputs are registered
`timescale 1ns/100ps
module gpd_pin_drive (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] impl_mask,
	input wire logic [7:0] alt_sel,
	input wire logic [7:0] alt_out,
	input wire logic [7:0] alt_oe,
	input wire logic [7:0] gp_dir,
	input wire logic [7:0] gp_data,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe
);

	logic [7:0] out_r;
	logic [7:0] out_nxt;
	logic [7:0] oe_r;
	logic [7:0] oe_nxt;

	always_comb begin
		// bits without a pin never drive
		out_nxt = ((alt_sel & alt_out) | (~alt_sel & gp_data)) & impl_mask;
		oe_nxt = ((alt_sel & alt_oe) | (~alt_sel & gp_dir)) & impl_mask;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_r <= 8'h00;
			oe_r <= 8'h00;
		end else begin
			out_r <= out_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign pin_out = out_r;
	assign pin_oe = oe_r;

endmodule : gpd_pin_drive

// ---- rtl/gpd_pkg.sv ----
// types shared by the two-port gpio block
// assumes nothing beyond the defines header
package gpd_pkg;

	typedef logic [7:0] gpd_byte_t;

	// one-hot register select, produced by the address decoder
	typedef enum logic [8:0] {
		GPD_SEL_NONE = 9'h001,
		GPD_SEL_P1_DIR = 9'h002,
		GPD_SEL_P1_DATA = 9'h004,
		GPD_SEL_P2_DIR = 9'h008,
		GPD_SEL_P2_DATA = 9'h010,
		GPD_SEL_P1_FUNC = 9'h020,
		GPD_SEL_P1_LEVEL = 9'h040,
		GPD_SEL_P2_LEVEL = 9'h080,
		GPD_SEL_ERR = 9'h100
	} gpd_sel_t;

endpackage : gpd_pkg

// ---- rtl/gpd_port_top.sv ----
// two 8-bit general i/o ports with direction and data registers
// assumes a simple register port on ref_clk and pins asynchronous to it
`timescale 1ns/100ps
`include "gpd_defines.svh"
module gpd_port_top (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] p1_pin_in,
	output logic [7:0] p1_pin_out,
	output logic [7:0] p1_pin_oe,
	input wire logic [7:0] p1_alt_out,
	input wire logic [7:0] p1_alt_oe,
	output logic [7:0] p1_pin_func,
	output logic [7:0] p1_pin_level,
	input wire logic [7:0] second_port_pins_in,
	output logic [7:0] second_port_pins_out,
	output logic [7:0] second_port_pins_oe,
	input wire logic [7:0] tmr_sel,
	input wire logic [7:0] tmr_out,
	input wire logic [7:0] tmr_oe,
	output logic [7:0] p2_pin_level
);

	// merge stored data with live pin level, picked per bit by direction
	function automatic gpd_pkg::gpd_byte_t gpd_read_merge(
		input gpd_pkg::gpd_byte_t dir,
		input gpd_pkg::gpd_byte_t dat,
		input gpd_pkg::gpd_byte_t lvl
	);
		gpd_read_merge = (dir & dat) | (~dir & lvl);
	endfunction : gpd_read_merge

	// address decoder shared by the write and read paths
	function automatic gpd_pkg::gpd_sel_t gpd_decode(input logic [7:0] addr);
		if (addr == `GPD_ADDR_P1_DIR) begin
			gpd_decode = gpd_pkg::GPD_SEL_P1_DIR;
		end else if (addr == `GPD_ADDR_P1_DATA) begin
			gpd_decode = gpd_pkg::GPD_SEL_P1_DATA;
		end else if (addr == `GPD_ADDR_P2_DIR) begin
			gpd_decode = gpd_pkg::GPD_SEL_P2_DIR;
		end else if (addr == `GPD_ADDR_P2_DATA) begin
			gpd_decode = gpd_pkg::GPD_SEL_P2_DATA;
		end else if (addr == `GPD_ADDR_P1_FUNC) begin
			gpd_decode = gpd_pkg::GPD_SEL_P1_FUNC;
		end else if (addr == `GPD_ADDR_P1_LEVEL) begin
			gpd_decode = gpd_pkg::GPD_SEL_P1_LEVEL;
		end else if (addr == `GPD_ADDR_P2_LEVEL) begin
			gpd_decode = gpd_pkg::GPD_SEL_P2_LEVEL;
		end else if (addr == `GPD_ADDR_ERR) begin
			gpd_decode = gpd_pkg::GPD_SEL_ERR;
		end else begin
			gpd_decode = gpd_pkg::GPD_SEL_NONE;
		end
	endfunction : gpd_decode

	gpd_pkg::gpd_sel_t wr_sel;
	gpd_pkg::gpd_sel_t rd_sel;

	gpd_pkg::gpd_byte_t p1_dir_r;
	gpd_pkg::gpd_byte_t p1_dir_nxt;
	gpd_pkg::gpd_byte_t p1_data_r;
	gpd_pkg::gpd_byte_t p1_data_nxt;
	gpd_pkg::gpd_byte_t p2_dir_r;
	gpd_pkg::gpd_byte_t p2_dir_nxt;
	gpd_pkg::gpd_byte_t p2_data_r;
	gpd_pkg::gpd_byte_t p2_data_nxt;
	gpd_pkg::gpd_byte_t p1_func_r;
	gpd_pkg::gpd_byte_t p1_func_nxt;
	gpd_pkg::gpd_byte_t err_r;
	gpd_pkg::gpd_byte_t err_nxt;
	gpd_pkg::gpd_byte_t rdata_r;
	gpd_pkg::gpd_byte_t rdata_nxt;

	gpd_pkg::gpd_byte_t p1_level;
	gpd_pkg::gpd_byte_t p2_level;
	gpd_pkg::gpd_byte_t p1_alt_sel;
	gpd_pkg::gpd_byte_t p1_rd_view;
	gpd_pkg::gpd_byte_t p2_rd_view;

	always_comb begin
		wr_sel = gpd_decode(reg_addr);
		rd_sel = gpd_decode(reg_addr);
	end

	// ------------------------------------------------------------------
	// pin level capture; the second flop output is the only one read
	// ------------------------------------------------------------------
	gpd_sync u_p1_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.async_in(p1_pin_in),
		.sync_out(p1_level)
	);

	gpd_sync u_p2_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.async_in(second_port_pins_in),
		.sync_out(p2_level)
	);

	// ------------------------------------------------------------------
	// first port direction register
	// ------------------------------------------------------------------
	always_comb begin
		p1_dir_nxt = p1_dir_r;
		if (reg_wr && wr_sel == gpd_pkg::GPD_SEL_P1_DIR) begin
			// each bit stored separately; bit 3 has no flop behind it
			p1_dir_nxt = reg_wdata & `GPD_P1_IMPL_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			p1_dir_r <= `GPD_DIR_RESET;
		end else begin
			p1_dir_r <= p1_dir_nxt;
		end
	end

	// ------------------------------------------------------------------
	// first port data register
	// ------------------------------------------------------------------
	always_comb begin
		p1_data_nxt = p1_data_r;
		if (reg_wr && wr_sel == gpd_pkg::GPD_SEL_P1_DATA) begin
			// the reserved bit is never stored, so a write cannot touch it
			p1_data_nxt = reg_wdata & `GPD_P1_IMPL_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			p1_data_r <= `GPD_DATA_RESET;
		end else begin
			p1_data_r <= p1_data_nxt;
		end
	end

	// ------------------------------------------------------------------
	// first port pin function selector: 1 hands the pin to a peripheral
	// ------------------------------------------------------------------
	always_comb begin
		p1_func_nxt = p1_func_r;
		if (reg_wr && wr_sel == gpd_pkg::GPD_SEL_P1_FUNC) begin
			p1_func_nxt = reg_wdata & `GPD_P1_IMPL_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			p1_func_r <= `GPD_FUNC_RESET;
		end else begin
			p1_func_r <= p1_func_nxt;
		end
	end

	// ------------------------------------------------------------------
	// second port direction and data registers
	// ------------------------------------------------------------------
	always_comb begin
		p2_dir_nxt = p2_dir_r;
		p2_data_nxt = p2_data_r;
		if (reg_wr && wr_sel == gpd_pkg::GPD_SEL_P2_DIR) begin
			p2_dir_nxt = reg_wdata;
		end
		if (reg_wr && wr_sel == gpd_pkg::GPD_SEL_P2_DATA) begin
			p2_data_nxt = reg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			p2_dir_r <= `GPD_DIR_RESET;
			p2_data_r <= `GPD_DATA_RESET;
		end else begin
			p2_dir_r <= p2_dir_nxt;
			p2_data_r <= p2_data_nxt;
		end
	end

	// ------------------------------------------------------------------
	// sticky access error flags, write 1 to clear; a new error wins
	// ------------------------------------------------------------------
	always_comb begin
		err_nxt = err_r;
		if (reg_wr && wr_sel == gpd_pkg::GPD_SEL_ERR) begin
			err_nxt = err_r & ~(reg_wdata & `GPD_ERR_MASK);
		end
		if (reg_wr && (wr_sel == gpd_pkg::GPD_SEL_NONE
			|| wr_sel == gpd_pkg::GPD_SEL_P1_LEVEL
			|| wr_sel == gpd_pkg::GPD_SEL_P2_LEVEL)) begin
			err_nxt[`GPD_ERR_WR_BIT] = 1'b1;
		end
		if (reg_rd && rd_sel == gpd_pkg::GPD_SEL_NONE) begin
			err_nxt[`GPD_ERR_RD_BIT] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			err_r <= 8'h00;
		end else begin
			err_r <= err_nxt;
		end
	end

	// ------------------------------------------------------------------
	// read path, answer registered one cycle after the strobe
	// ------------------------------------------------------------------
	always_comb begin
		// output bits give stored data, input bits give the pin
		p1_rd_view = gpd_read_merge(p1_dir_r, p1_data_r, p1_level)
			& `GPD_P1_IMPL_MASK;
		p1_rd_view = p1_rd_view | `GPD_P1_RSVD_MASK;
		p2_rd_view = gpd_read_merge(p2_dir_r, p2_data_r, p2_level);
	end

	always_comb begin
		// held at zero between reads so a stale value is never seen
		rdata_nxt = `GPD_RDATA_RESET;
		if (reg_rd) begin
			if (rd_sel == gpd_pkg::GPD_SEL_P1_DATA) begin
				rdata_nxt = p1_rd_view;
			end else if (rd_sel == gpd_pkg::GPD_SEL_P2_DATA) begin
				rdata_nxt = p2_rd_view;
			end else if (rd_sel == gpd_pkg::GPD_SEL_P1_DIR
				|| rd_sel == gpd_pkg::GPD_SEL_P2_DIR) begin
				// write-only: the stored bits are not exposed
				rdata_nxt = `GPD_DIR_RDATA;
			end else if (rd_sel == gpd_pkg::GPD_SEL_P1_FUNC) begin
				rdata_nxt = p1_func_r;
			end else if (rd_sel == gpd_pkg::GPD_SEL_P1_LEVEL) begin
				rdata_nxt = p1_level & `GPD_P1_IMPL_MASK;
			end else if (rd_sel == gpd_pkg::GPD_SEL_P2_LEVEL) begin
				rdata_nxt = p2_level;
			end else if (rd_sel == gpd_pkg::GPD_SEL_ERR) begin
				rdata_nxt = err_r;
			end else begin
				rdata_nxt = `GPD_UNMAPPED_RDATA;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= `GPD_RDATA_RESET;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------------
	always_comb begin
		// direction only counts on pins left as general i/o
		p1_alt_sel = p1_func_r;
	end

	// driver gates direction by selector and drops bit 3
	gpd_pin_drive u_p1_drive (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.impl_mask(`GPD_P1_IMPL_MASK),
		.alt_sel(p1_alt_sel),
		.alt_out(p1_alt_out),
		.alt_oe(p1_alt_oe),
		.gp_dir(p1_dir_r),
		.gp_data(p1_data_r),
		.pin_out(p1_pin_out),
		.pin_oe(p1_pin_oe)
	);

	// timer selection wins over general direction and data
	gpd_pin_drive u_p2_drive (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.impl_mask(8'hff),
		.alt_sel(tmr_sel),
		.alt_out(tmr_out),
		.alt_oe(tmr_oe),
		.gp_dir(p2_dir_r),
		.gp_data(p2_data_r),
		.pin_out(second_port_pins_out),
		.pin_oe(second_port_pins_oe)
	);

	assign reg_rdata = rdata_r;
	assign p1_pin_func = p1_func_r;
	assign p1_pin_level = p1_level;
	assign p2_pin_level = p2_level;

endmodule : gpd_port_top

// ---- rtl/gpd_sync.sv ----
// two-flop synchroniser for a byte of pin levels
// assumes pins are asynchronous to ref_clk
`timescale 1ns/100ps
module gpd_sync (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] async_in,
	output logic [7:0] sync_out
);

	logic [7:0] meta_r;
	logic [7:0] meta_nxt;
	logic [7:0] sync_r;
	logic [7:0] sync_nxt;

	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	// meta_r feeds only sync_r
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= 8'h00;
			sync_r <= 8'h00;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;

endmodule : gpd_sync
